/* File: hw/irq_flag_pkg.sv */
`default_nettype none
package irq_flag_pkg;
  // ----------------------------------------
  // Source layout
  // ----------------------------------------
  localparam int SRC_COUNT = 18;
  localparam int PIN_COUNT = 6;
  localparam int INT_EVT_COUNT = 12;
  localparam int PIN_FIRST_IDX = 1;
  localparam int SHARED_SERIAL_IDX = 10;
  localparam int EXT_USED_BITS = 2;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_PEND_LOW = 16'hffe0;
  localparam logic [15:0] ADDR_PEND_HIGH = 16'hffe1;
  localparam logic [15:0] ADDR_PEND_EXT = 16'hffe2;
  localparam logic [15:0] ADDR_MASK_LOW = 16'hffe4;
  localparam logic [15:0] ADDR_MASK_HIGH = 16'hffe5;
  localparam logic [15:0] ADDR_MASK_EXT = 16'hffe6;
  localparam logic [15:0] ADDR_PRIO_LOW = 16'hffe8;
  localparam logic [15:0] ADDR_PRIO_HIGH = 16'hffe9;
  localparam logic [15:0] ADDR_PRIO_EXT = 16'hffea;
  localparam logic [15:0] ADDR_RISE_EN = 16'hff48;
  localparam logic [15:0] ADDR_FALL_EN = 16'hff49;

  // ----------------------------------------
  // Reset values and fixed read bits
  // ----------------------------------------
  localparam logic [7:0] PEND_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [5:0] EXT_FILL_ONES = 6'h3f;
  localparam logic [5:0] EXT_FILL_ZERO = 6'h00;
  localparam logic [1:0] EDGE_FILL = 2'h0;
endpackage : irq_flag_pkg
`default_nettype wire

/* File: hw/pin_edge_if.sv */
`default_nettype none
interface pin_edge_if #(
  parameter int N = 6
);
  logic [N-1:0] pin_level;
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic [N-1:0] edge_evt;

  // Controller side supplies pins and enables, takes events
  modport ctrl (output pin_level, output rise_en, output fall_en, input edge_evt);
  // Detector side
  modport det (input pin_level, input rise_en, input fall_en, output edge_evt);
endinterface : pin_edge_if
`default_nettype wire

/* File: hw/pin_edge_detect.sv */
`default_nettype none
module pin_edge_detect #(
  parameter int N = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pin_edge_if.det eif
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;
    logic [N-1:0] level;
    logic [N-1:0] evt;
  } det_state_t;

  det_state_t s_q;
  det_state_t s_d;

  // Enables arrive through one byte, so more than eight pins cannot be served
  if (N < 1 || N > 8) begin : g_bad_width
    $error("pin_edge_detect: N must be 1 to 8");
  end

  // Three-stage sync; a change counts once stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.sync1 = eif.pin_level;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < N; i++) begin
      s_d.evt[i] = 1'b0;
      if (s_q.sync2[i] == s_q.sync3[i] && s_q.sync3[i] != s_q.level[i]) begin
        s_d.level[i] = s_q.sync3[i];
        // Edge qualified by its enable pair: 00 none, 01 fall, 10 rise, 11 both
        s_d.evt[i] = s_q.sync3[i] ? eif.rise_en[i] : eif.fall_en[i]; // RULE_20
      end
    end
  end

  // Level starts low, so a pin held high at reset looks like a rising edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign eif.edge_evt = s_q.evt;
endmodule : pin_edge_detect
`default_nettype wire

/* File: hw/interrupt_request_flag_unit.sv */
// Function
// RULE_01: A source request or a software write of 1 sets its pending flag.
// RULE_02: CPU acknowledge clears that source's pending flag before service starts.
// RULE_03: Reset clears all three pending registers to zero.
// RULE_04: Pending registers take bit or byte access; low pair reads as one word.
// RULE_05: First register: low voltage, pins 0 to 5, serial 6 receive error.
// RULE_06: Second register: serial 6 rx/tx end, shared serial, five timer sources.
// RULE_07: Third register: A/D end in bit 0, UART0 receive in bit 1.
// RULE_08: Software writes zero to bits 2 to 7 of the third register.
// RULE_09: A flag reads 0 with no request and 1 while one is pending.
// RULE_10: The shared serial flag sets on either of its two sources.
// RULE_11: Software clears flags with single-bit operations, not byte read-modify-write.
// RULE_12: A byte write replaces all eight flags, losing a set since the read.
// RULE_13: After standby release software clears stale flags before using a peripheral.
// RULE_14: Six register groups: pending, mask, priority, rise, fall, status word.
// RULE_15: Each source has pending, mask and priority flags at the same bit.
// RULE_16: Acknowledge logic combines pending, mask, priority, global enable and in-service.
// RULE_17: External pins pass edge detection; internal sources set flags directly.
// RULE_18: Mask 0 allows, 1 blocks; reset sets all masks to 1.
// RULE_19: Priority 0 is high group, 1 low; high may nest over low.
// RULE_20: Edge enable pair per pin: 00 none, 01 fall, 10 rise, 11 both.
// RULE_21: Equal-group simultaneous requests resolve by fixed order, index 0 highest.
// RULE_22: With global enable, present the top pending unmasked request to the CPU.
`default_nettype none
module interrupt_request_flag_unit
  import irq_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  input wire logic rd_i,
  input wire logic rd_word_i,
  output logic [15:0] rdata_o,
  input wire logic [INT_EVT_COUNT-1:0] internal_evt_i,
  input wire logic uart0_tx_evt_i,
  input wire logic [PIN_COUNT-1:0] ext_pin_irq_i,
  input wire logic global_interrupt_enable_i,
  input wire logic in_service_priority_i,
  input wire logic ack_i,
  output logic irq_req_o,
  output logic [4:0] irq_index_o,
  output logic irq_low_group_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [SRC_COUNT-1:0] pend;
    logic [SRC_COUNT-1:0] mask;
    logic [SRC_COUNT-1:0] prio;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [15:0] rdata;
    logic req;
    logic [4:0] idx;
    logic grp;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte write replaces; bit write touches only the addressed bit
  function automatic logic [7:0] reg_write(input logic [7:0] old, input logic byte_wr,
                                           input logic [7:0] data, input logic [2:0] sel,
                                           input logic val);
    logic [7:0] r;
    r = old;
    if (byte_wr) begin
      r = data; // RULE_04
    end else begin
      r[sel] = val; // RULE_04
    end
    return r;
  endfunction : reg_write

  // Lowest set index wins the fixed order
  function automatic logic [4:0] first_set(input logic [SRC_COUNT-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = SRC_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i); // RULE_21
      end
    end
    return r;
  endfunction : first_set

  // ----------------------------------------
  // Edge detection of the external pins
  // ----------------------------------------
  pin_edge_if #(.N(PIN_COUNT)) eif ();

  assign eif.pin_level = ext_pin_irq_i;
  assign eif.rise_en = s_q.rise;
  assign eif.fall_en = s_q.fall;

  pin_edge_detect #(.N(PIN_COUNT)) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .eif(eif)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [SRC_COUNT-1:0] set_v;
  logic [SRC_COUNT-1:0] elig;
  logic [SRC_COUNT-1:0] hi_v;
  logic [SRC_COUNT-1:0] lo_v;
  logic sw_wr;
  logic [7:0] tmp;

  always_comb begin
    s_d = s_q;
    sw_wr = wr_i | bit_wr_i;
    tmp = '0;
    // Hardware sets: pins via edge stage, internal events direct
    set_v = '0;
    set_v[0] = internal_evt_i[0]; // RULE_05
    set_v[PIN_FIRST_IDX +: PIN_COUNT] = eif.edge_evt; // RULE_17
    set_v[SRC_COUNT-1:PIN_FIRST_IDX+PIN_COUNT] = internal_evt_i[INT_EVT_COUNT-1:1]; // RULE_06
    set_v[SHARED_SERIAL_IDX] = internal_evt_i[4] | uart0_tx_evt_i; // RULE_10

    // Software access to the five device-side register groups
    if (sw_wr) begin
      unique case (addr_i)
        ADDR_PEND_LOW: begin
          s_d.pend[7:0] = reg_write(s_q.pend[7:0], wr_i, wdata_i, bit_sel_i, bit_val_i);
          if (wr_i) begin
            set_v[7:0] = '0; // RULE_12
          end
        end
        ADDR_PEND_HIGH: begin
          s_d.pend[15:8] = reg_write(s_q.pend[15:8], wr_i, wdata_i, bit_sel_i, bit_val_i);
          if (wr_i) begin
            set_v[15:8] = '0; // RULE_12
          end
        end
        ADDR_PEND_EXT: begin
          tmp = reg_write({EXT_FILL_ZERO, s_q.pend[17:16]}, wr_i, wdata_i, bit_sel_i,
                          bit_val_i);
          s_d.pend[17:16] = tmp[EXT_USED_BITS-1:0]; // RULE_07
          if (wr_i) begin
            set_v[17:16] = '0; // RULE_12
          end
        end
        ADDR_MASK_LOW: s_d.mask[7:0] = reg_write(s_q.mask[7:0], wr_i, wdata_i, bit_sel_i,
                                                 bit_val_i); // RULE_14
        ADDR_MASK_HIGH: s_d.mask[15:8] = reg_write(s_q.mask[15:8], wr_i, wdata_i, bit_sel_i,
                                                   bit_val_i); // RULE_15
        ADDR_MASK_EXT: begin
          tmp = reg_write({EXT_FILL_ONES, s_q.mask[17:16]}, wr_i, wdata_i, bit_sel_i,
                          bit_val_i);
          s_d.mask[17:16] = tmp[EXT_USED_BITS-1:0];
        end
        ADDR_PRIO_LOW: s_d.prio[7:0] = reg_write(s_q.prio[7:0], wr_i, wdata_i, bit_sel_i,
                                                 bit_val_i); // RULE_14
        ADDR_PRIO_HIGH: s_d.prio[15:8] = reg_write(s_q.prio[15:8], wr_i, wdata_i, bit_sel_i,
                                                   bit_val_i); // RULE_15
        ADDR_PRIO_EXT: begin
          tmp = reg_write({EXT_FILL_ONES, s_q.prio[17:16]}, wr_i, wdata_i, bit_sel_i,
                          bit_val_i);
          s_d.prio[17:16] = tmp[EXT_USED_BITS-1:0];
        end
        ADDR_RISE_EN: begin
          tmp = reg_write({EDGE_FILL, s_q.rise}, wr_i, wdata_i, bit_sel_i, bit_val_i);
          s_d.rise = tmp[PIN_COUNT-1:0]; // RULE_20
        end
        ADDR_FALL_EN: begin
          tmp = reg_write({EDGE_FILL, s_q.fall}, wr_i, wdata_i, bit_sel_i, bit_val_i);
          s_d.fall = tmp[PIN_COUNT-1:0]; // RULE_20
        end
        default: ;
      endcase
    end

    // Acknowledge clears the presented flag; a new set in that cycle still wins
    if (ack_i && s_q.req) begin
      s_d.pend[s_q.idx] = 1'b0; // RULE_02
    end
    s_d.pend = s_d.pend | set_v; // RULE_01

    // Arbitrate on updated flags so an acknowledged source is never offered twice
    elig = s_d.pend & ~s_d.mask; // RULE_18
    hi_v = elig & ~s_d.prio; // RULE_19
    lo_v = elig & s_d.prio & {SRC_COUNT{in_service_priority_i}}; // RULE_16
    s_d.req = global_interrupt_enable_i && ((|hi_v) || (|lo_v)); // RULE_22
    s_d.grp = ~(|hi_v);
    s_d.idx = (|hi_v) ? first_set(hi_v) : first_set(lo_v); // RULE_21

    // Registered read data, one cycle after the strobe
    if (rd_i) begin
      unique case (addr_i)
        ADDR_PEND_LOW: s_d.rdata = rd_word_i ? s_q.pend[15:0]
                                             : {8'h00, s_q.pend[7:0]}; // RULE_09
        ADDR_PEND_HIGH: s_d.rdata = {8'h00, s_q.pend[15:8]};
        ADDR_PEND_EXT: s_d.rdata = {8'h00, EXT_FILL_ZERO, s_q.pend[17:16]};
        ADDR_MASK_LOW: s_d.rdata = rd_word_i ? s_q.mask[15:0] : {8'h00, s_q.mask[7:0]};
        ADDR_MASK_HIGH: s_d.rdata = {8'h00, s_q.mask[15:8]};
        ADDR_MASK_EXT: s_d.rdata = {8'h00, EXT_FILL_ONES, s_q.mask[17:16]};
        ADDR_PRIO_LOW: s_d.rdata = rd_word_i ? s_q.prio[15:0] : {8'h00, s_q.prio[7:0]};
        ADDR_PRIO_HIGH: s_d.rdata = {8'h00, s_q.prio[15:8]};
        ADDR_PRIO_EXT: s_d.rdata = {8'h00, EXT_FILL_ONES, s_q.prio[17:16]};
        ADDR_RISE_EN: s_d.rdata = {8'h00, EDGE_FILL, s_q.rise};
        ADDR_FALL_EN: s_d.rdata = {8'h00, EDGE_FILL, s_q.fall};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.pend <= {PEND_RESET[EXT_USED_BITS-1:0], PEND_RESET, PEND_RESET}; // RULE_03
      s_q.mask <= {MASK_RESET[EXT_USED_BITS-1:0], MASK_RESET, MASK_RESET}; // RULE_18
      s_q.prio <= {PRIO_RESET[EXT_USED_BITS-1:0], PRIO_RESET, PRIO_RESET};
      s_q.rise <= EDGE_RESET[PIN_COUNT-1:0];
      s_q.fall <= EDGE_RESET[PIN_COUNT-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign irq_req_o = s_q.req;
  assign irq_index_o = s_q.idx;
  assign irq_low_group_o = s_q.grp;
endmodule : interrupt_request_flag_unit
`default_nettype wire

/* File: test/irq_flag_assertions.sv */
`default_nettype none
module irq_flag_checker
  import irq_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic bit_wr_i,
  input wire logic rd_i,
  input wire logic rd_word_i,
  input wire logic [15:0] rdata_o,
  input wire logic [INT_EVT_COUNT-1:0] internal_evt_i,
  input wire logic uart0_tx_evt_i,
  input wire logic global_interrupt_enable_i,
  input wire logic in_service_priority_i,
  input wire logic ack_i,
  input wire logic irq_req_o,
  input wire logic [4:0] irq_index_o,
  input wire logic irq_low_group_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // Port relations on the one clock
  // ------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_BYTE_UPPER:
    assert property (rd_i && !rd_word_i |=> rdata_o[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  AST_READ_HOLD:
    assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_UNMAPPED:
    assert property (rd_i && addr_i == 16'h0000 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_EXT_UNUSED:
    assert property (rd_i && addr_i == ADDR_PEND_EXT |=> rdata_o[7:2] == 6'h00)
    else $error("unused flag bits read as one");
  // Mid cycle excludes anything else that could touch the two used bits
  AST_WRITE_BACK:
    assert property (wr_i && addr_i == ADDR_PEND_EXT && !ack_i
      ##1 !wr_i && !bit_wr_i && !ack_i && internal_evt_i[11:10] == 2'b00
      ##1 rd_i && addr_i == ADDR_PEND_EXT |=> rdata_o[1:0] == $past(wdata_i[1:0], 3))
    else $error("byte write not read back");
  AST_INDEX_RANGE:
    assert property (irq_req_o |-> irq_index_o <= 5'h11)
    else $error("request index out of range");
  AST_GLOBAL_OFF:
    assert property (!global_interrupt_enable_i |=> !irq_req_o)
    else $error("request while globally disabled");
  AST_LOW_GROUP:
    assert property (irq_req_o && irq_low_group_o |-> $past(in_service_priority_i))
    else $error("low group presented while blocked");
  AST_ACK_CLEARS:
    assert property (ack_i && irq_req_o && irq_index_o >= 5'h07 && internal_evt_i == 12'h000
      && !uart0_tx_evt_i && !wr_i && !bit_wr_i
      |=> !irq_req_o || irq_index_o != $past(irq_index_o))
    else $error("acknowledged source still presented");
endmodule : irq_flag_checker
`default_nettype wire

/* File: test/cpu_ack_model.sv */
`default_nettype none
module cpu_ack_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [3:0] delay_i,
  input wire logic irq_req_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // Acts on the falling edge so the request is settled; one-cycle ack pulse
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i || !en_i || ack_o || !irq_req_i) begin
      ack_o <= 1'b0;
      wait_n = 0;
    end else if (wait_n < int'(delay_i)) begin
      wait_n = wait_n + 1; // Slow CPU: latency before taking the request
    end else begin
      ack_o <= 1'b1;
    end
  end
endmodule : cpu_ack_model
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench import irq_flag_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, bit_wr_i = 1'b0, bit_val_i = 1'b0;
  logic rd_i = 1'b0, rd_word_i = 1'b0, uart0_tx_evt_i = 1'b0, ack_i, ack_en = 1'b0;
  logic global_interrupt_enable_i = 1'b0, in_service_priority_i = 1'b0;
  logic irq_req_o, irq_low_group_o;
  logic [15:0] addr_i = 16'h0000, rdata_o, v;
  logic [7:0] wdata_i = 8'h00;
  logic [2:0] bit_sel_i = 3'h0;
  logic [11:0] internal_evt_i = 12'h000;
  logic [5:0] ext_pin_irq_i = 6'h00;
  logic [4:0] irq_index_o;
  logic [3:0] ack_delay = 4'h0;
  logic [31:0] seed = 32'h0000_ed8e, r;
  logic [23:0] p;
  logic [5:0] acked[$];
  int num_errors = 0, num_checks = 0, j;
  interrupt_request_flag_unit DUT (.clk_i, .rst_i, .addr_i, .wr_i, .wdata_i, .bit_wr_i,
    .bit_sel_i, .bit_val_i, .rd_i, .rd_word_i, .rdata_o, .internal_evt_i, .uart0_tx_evt_i,
    .ext_pin_irq_i, .global_interrupt_enable_i, .in_service_priority_i, .ack_i, .irq_req_o,
    .irq_index_o, .irq_low_group_o);
  cpu_ack_model cpu (.clk_i, .rst_i, .en_i(ack_en), .delay_i(ack_delay),
    .irq_req_i(irq_req_o), .ack_o(ack_i));
  always #10 clk_i = ~clk_i;
  // Log every taken acknowledge in order, with its group
  always @(posedge clk_i) if (ack_i && irq_req_o) acked.push_back({irq_low_group_o, irq_index_o});
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int evt_idx(input int i);
    return (i == 0) ? 0 : (i == 12) ? 10 : i + 6;
  endfunction : evt_idx
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask : wr
  task automatic clr();
    wr(ADDR_PEND_LOW, 8'h00);
    wr(ADDR_PEND_HIGH, 8'h00);
    wr(ADDR_PEND_EXT, 8'h00);
  endtask : clr
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic rchk(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(negedge clk_i);
    addr_i = a;
    rd_word_i = w;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk($sformatf("read %h", a), e, rdata_o);
  endtask : rchk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Generous bound; the sequence needs well under a fifth of it
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rchk(ADDR_PEND_LOW, 1'b1, 16'h0000);
    rchk(ADDR_PEND_EXT, 1'b0, 16'h0000);
    rchk(ADDR_MASK_LOW, 1'b1, 16'hffff);
    rchk(ADDR_MASK_EXT, 1'b0, 16'h00ff);
    rchk(ADDR_FALL_EN, 1'b0, 16'h0000);
    rchk(16'h0000, 1'b0, 16'h0000);
    $display("test reset finished");
    repeat (4) begin
      r = rnd();
      wr(ADDR_PEND_LOW, r[7:0]);
      wr(ADDR_PEND_HIGH, r[15:8]);
      wr(ADDR_PEND_EXT, {6'h00, r[17:16]});
      rchk(ADDR_PEND_EXT, 1'b0, {14'h0000, r[17:16]});
      rchk(ADDR_PEND_LOW, 1'b1, r[15:0]);
    end
    clr();
    v = 16'h0000;
    // Set each bit, then clear each, one bit per access
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      addr_i = ADDR_PEND_HIGH;
      bit_sel_i = i[2:0];
      bit_val_i = (i < 8);
      bit_wr_i = 1'b1;
      @(negedge clk_i);
      bit_wr_i = 1'b0;
      v[i[2:0]] = (i < 8);
      rchk(ADDR_PEND_HIGH, 1'b0, v);
    end
    $display("test registers finished");
    for (int i = 0; i < 13; i++) begin
      clr();
      @(negedge clk_i);
      internal_evt_i = (i < 12) ? 12'h001 << i : 12'h000;
      uart0_tx_evt_i = (i == 12);
      @(negedge clk_i);
      internal_evt_i = 12'h000;
      uart0_tx_evt_i = 1'b0;
      p = 24'h00_0001 << evt_idx(i);
      rchk(ADDR_PEND_LOW, 1'b1, p[15:0]);
      rchk(ADDR_PEND_EXT, 1'b0, {8'h00, p[23:16]});
    end
    for (int m = 0; m < 4; m++) begin
      j = int'(rnd() % 6);
      wr(ADDR_RISE_EN, {7'h00, m[1]} << j);
      wr(ADDR_FALL_EN, {7'h00, m[0]} << j);
      clr();
      for (int lv = 1; lv >= 0; lv--) begin
        ext_pin_irq_i[j] = lv[0];
        repeat (6) @(negedge clk_i);
        rchk(ADDR_PEND_LOW, 1'b0, {15'h0000, lv[0] ? m[1] : m[0]} << (j + 1));
        clr();
      end
    end
    $display("test sources finished");
    wr(ADDR_MASK_LOW, 8'h00);
    wr(ADDR_MASK_HIGH, 8'h00);
    wr(ADDR_MASK_EXT, 8'hfc);
    wr(ADDR_PRIO_EXT, 8'hfe);
    ack_delay = 4'(rnd() % 5);
    global_interrupt_enable_i = 1'b1;
    ack_en = 1'b1;
    @(negedge clk_i);
    internal_evt_i = 12'hfff;
    @(negedge clk_i);
    internal_evt_i = 12'h000;
    repeat (12) @(negedge clk_i);
    chk("blocked low group", 16'h0000, {15'h0000, irq_req_o});
    in_service_priority_i = 1'b1;
    repeat (100) @(negedge clk_i);
    chk("ack count", 16'h000c, 16'(acked.size()));
    for (int i = 0; i < 12; i++) begin
      // Bit 5 is the low group flag: only source 16, taken first, is high group
      chk("ack order", 16'((i == 0) ? 16 : 32 + ((i == 1) ? 0 : (i == 11) ? 17 : i + 5)),
        {10'h000, acked[i]});
    end
    rchk(ADDR_PEND_LOW, 1'b1, 16'h0000);
    $display("test acknowledge finished");
    print_verdict();
  end
endmodule : testbench
bind interrupt_request_flag_unit irq_flag_checker chk (.clk_i, .rst_i, .addr_i, .wr_i,
  .wdata_i, .bit_wr_i, .rd_i, .rd_word_i, .rdata_o, .internal_evt_i, .uart0_tx_evt_i,
  .global_interrupt_enable_i, .in_service_priority_i, .ack_i, .irq_req_o, .irq_index_o,
  .irq_low_group_o);
`default_nettype wire
